// >>> irt_asserts.sv
// Port checker for the infrared timer
`timescale 1ns/10ps
module irt_asserts import irt_pkg::*; (
   input wire logic clock,
   input wire logic resetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic ir_tx_pin,
   input wire logic ir_tx_pin_oe_n,
   input wire logic timer_irq
);
   logic wr, q;
   logic [7:0] wa, st;
   logic [15:0] run, m;
   logic [1:0] p;
   irt_ctl_t c;
   irt_carrier_t k;
   default clocking @(posedge clock); endclocking
   default disable iff (!resetn);
   // Shadow of the control, carrier, interval and power registers and length of the current pin level
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         wr <= 1'b0;
         q <= 1'b0;
         wa <= 8'h00;
         st <= 8'h00;
         run <= 16'h0000;
         m <= 16'h0000;
         p <= 2'h0;
         c <= '0;
         k <= '0;
      end else begin
         wr <= hsel && hready && htrans == HTRANS_NONSEQ && hwrite;
         wa <= haddr[7:0];
         q <= ir_tx_pin;
         run <= (ir_tx_pin != q) ? 16'h0001 : run + 16'h0001;
         st <= (st == 8'hFF) ? st : st + 8'h01;
         if (wr) begin
            case (wa)
               ADDR_CONTROL: c <= irt_ctl_t'(hwdata[10:0]);
               ADDR_CARRIER: k <= irt_carrier_t'(hwdata[15:0]);
               ADDR_INTERVAL: m <= hwdata[15:0];
               ADDR_POWER: p <= hwdata[1:0];
               default: ;
            endcase
            if (wa <= ADDR_INTERVAL) st <= 8'h00;
         end
      end
   end
   property p_manual;
      !c.enable && st > 8'h01 |-> ir_tx_pin_oe_n == !p[PWR_OE]
         && (!p[PWR_OE] || ir_tx_pin == p[PWR_LEVEL]);
   endproperty
   a_manual: assert property (p_manual) else $error("manual pin wrong");
   property p_driven;
      c.enable && $past(c.enable) |-> !ir_tx_pin_oe_n;
   endproperty
   a_driven: assert property (p_driven) else $error("pin not driven");
   property p_rx_idle;
      c.enable && !c.mode && st > 8'h02 |-> ir_tx_pin == c.pol;
   endproperty
   a_rx_idle: assert property (p_rx_idle) else $error("idle level wrong");
   property p_data0;
      c.enable && c.mode && !c.data && st == 8'hFF |-> ir_tx_pin == c.pol;
   endproperty
   a_data0: assert property (p_data0) else $error("carrier with data 0");
   property p_carrier;
      c.enable && c.mode && c.data && !c.clksel && st > 8'h80 && ir_tx_pin != q && run < st
         |-> run == ((q ^ c.pol) ? 16'(k.high) + 16'h1 : 16'(k.low) + 16'h1) << c.div;
   endproperty
   a_carrier: assert property (p_carrier) else $error("carrier phase length");
   property p_fine;
      c.enable && c.mode && c.data && !c.pol && c.clksel && 16'(k.high) < m
         && 16'(k.high) + 16'(k.low) >= m && st > 8'h80 && ir_tx_pin != q && run < st
         |-> run == (q ? 16'(k.high) + 16'h1 : m - 16'(k.high)) << c.div;
   endproperty
   a_fine: assert property (p_fine) else $error("interval length");
   property p_irq_mask;
      !c.ie && !$past(c.ie) |-> !timer_irq;
   endproperty
   a_irq_mask: assert property (p_irq_mask) else $error("irq while masked");
   property p_bus;
      hreadyout && !hresp;
   endproperty
   a_bus: assert property (p_bus) else $error("bus response wrong");
   c_tx: cover property (c.enable && c.mode && ir_tx_pin != q);
   c_rx: cover property (c.enable && !c.mode && timer_irq);
   c_man: cover property (!c.enable && p[PWR_OE] && ir_tx_pin);
endmodule : irt_asserts

// >>> irt_ir_partner.sv
// Emitter driver and receiver front end model
`timescale 1ns/10ps
module irt_ir_partner (
   input wire logic clock,
   input wire logic resetn,
   input wire logic ir_tx_pin,
   input wire logic ir_tx_pin_oe_n,
   input wire logic rx_level,
   output logic ir_rx_pin,
   output logic [15:0] high_run,
   output logic [15:0] low_run
);
   logic q;
   logic [15:0] run;
   wire lit = !ir_tx_pin_oe_n && ir_tx_pin;
   // Emitter keeps the length of the last lit and dark spans
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         q <= 1'b0;
         run <= 16'h0000;
         high_run <= 16'h0000;
         low_run <= 16'h0000;
         ir_rx_pin <= 1'b0;
      end else begin
         q <= lit;
         ir_rx_pin <= rx_level;
         run <= (lit != q) ? 16'h0001 : run + 16'h0001;
         if (lit != q && q) high_run <= run;
         if (lit != q && !q) low_run <= run;
      end
   end
endmodule : irt_ir_partner

// >>> irt_pkg.sv
// Package for the infrared carrier modulation timer
package irt_pkg;
   localparam logic [7:0] ADDR_CONTROL = 8'h00;
   localparam logic [7:0] ADDR_CARRIER = 8'h04;
   localparam logic [7:0] ADDR_INTERVAL = 8'h08;
   localparam logic [7:0] ADDR_COUNTER = 8'h0C;
   localparam logic [7:0] ADDR_STATUS = 8'h10;
   localparam logic [7:0] ADDR_POWER = 8'h14;
   // Control register bit positions
   localparam int CTL_ENABLE = 0;
   localparam int CTL_MODE = 1;
   localparam int CTL_CLKSEL = 2;
   localparam int CTL_POL = 3;
   localparam int CTL_DATA = 4;
   localparam int CTL_IE = 5;
   localparam int CTL_RELOAD = 6;
   localparam int CTL_EDGE_LO = 7;
   localparam int CTL_DIV_LO = 9;
   // Status register bit positions
   localparam int STS_IF = 0;
   localparam int STS_OV = 1;
   // Power control bit positions
   localparam int PWR_LEVEL = 0;
   localparam int PWR_OE = 1;
   localparam logic [15:0] CNT_ZERO = 16'h0000;
   localparam logic [15:0] CNT_MAX = 16'hFFFF;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [1:0] EDGE_FALL = 2'h1;
   localparam logic [1:0] EDGE_RISE = 2'h2;
   localparam logic [1:0] EDGE_BOTH = 2'h3;

   typedef struct packed {
      logic [1:0] div;
      logic [1:0] edge_sel;
      logic reload;
      logic ie;
      logic data;
      logic pol;
      logic clksel;
      logic mode;
      logic enable;
   } irt_ctl_t;

   typedef struct packed {
      logic [7:0] high;
      logic [7:0] low;
   } irt_carrier_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_TX = 2'b01,
      ST_RX_WAIT = 2'b10,
      ST_RX_RUN = 2'b11
   } irt_state_t;
endpackage : irt_pkg

// >>> irt_timer.sv
// Infrared carrier generator, modulator and capture timer with AHB-Lite registers
//
// The AHB-Lite register port and the register offsets are this design's own decisions.
`timescale 1ns/10ps
// How it works
// (R1) Disabled: tx pin follows manual level, gated by manual drive enable.
// (R2) Carrier timing is 16 bits: high byte high time, low byte low time.
// (R3) Input clock is system clock divided by two to the divider field.
// (R4) High phase lasts high+1, low phase low+1 input clocks.
// (R5) Carrier, data and polarity are latched at every interval start.
// (R6) Enabled: pin idles at polarity level; polarity also inverts carrier.
// (R7) Transmit counter clocked by carrier cycles, or input clock when selected.
// (R8) Data 1 sends carrier on pin, data 0 holds idle level.
// (R9) Transmit starts when enable and transmit mode both become set.
// (R10) At zero, next tick reloads, resamples, updates pin, sets timer flag.
// (R11) Each interval lasts interval count plus one counter clocks.
// (R12) Software stops transmit by picking receive mode or clearing enable.
// (R13) Counter wrap from FFFF to 0000 sets the overflow flag.
// (R14) Two-bit edge select picks which receive edges qualify.
// (R15) Receive runs with mode 0, enable 1; counting starts at first edge.
// (R16) Receive counter counts carrier cycles, or input clocks when selected.
// (R17) Later edges store pin level in data bit and counter in interval.
// (R18) After capture counter clears if reload set, else keeps running.
// (R19) Receive continues until transmit mode is set or enable is cleared.
// (R20) Every receive capture sets the timer flag.
// (R21) Software clears the flags by writing zero; hardware only sets them.
module irt_timer (
   input wire logic clock,
   input wire logic resetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic ir_rx_pin,
   output logic ir_tx_pin,
   output logic ir_tx_pin_oe_n,
   output logic timer_irq
);
   import irt_pkg::*;

   irt_ctl_t ctl, next_ctl;
   irt_carrier_t carrier, next_carrier;
   logic [15:0] interval, next_interval;
   logic [15:0] counter, next_counter;
   logic flag_if, next_flag_if;
   logic flag_ov, next_flag_ov;
   logic manual_tx_level, next_manual_tx_level;
   logic manual_tx_drive_enable, next_manual_tx_drive_enable;
   logic wr_pend, next_wr_pend;
   logic [7:0] wr_addr, next_wr_addr;
   logic [31:0] next_hrdata;
   // Engine state
   irt_state_t state, next_state;
   logic [3:0] div_cnt, next_div_cnt;
   logic [7:0] phase_cnt, next_phase_cnt;
   logic phase_high, next_phase_high;
   irt_carrier_t lat_carrier, next_lat_carrier;
   logic lat_data, next_lat_data;
   logic lat_pol, next_lat_pol;
   logic rx_meta, rx_sync, rx_prev;
   logic next_tx_pin, next_tx_oe_n, next_irq;

   // Divider, carrier and edge detection
   logic ir_input_clock;
   logic carrier_tick;
   logic cnt_tick;
   logic rx_rise, rx_fall, rx_qual;
   logic [3:0] div_top;
   logic [7:0] phase_top;
   logic bus_req;

   always_comb begin
      div_top = 4'((4'h1 << ctl.div) - 4'h1);  // see (R3)
      ir_input_clock = (div_cnt >= div_top);
      phase_top = phase_high ? lat_carrier.high : lat_carrier.low;  // see (R2)
      carrier_tick = ir_input_clock && !phase_high && (phase_cnt >= phase_top);  // see (R4)
      cnt_tick = ctl.clksel ? ir_input_clock : carrier_tick;  // see (R7) see (R16)
      rx_rise = rx_sync && !rx_prev;
      rx_fall = !rx_sync && rx_prev;
      case (ctl.edge_sel)  // see (R14)
         EDGE_FALL: rx_qual = rx_fall;
         EDGE_RISE: rx_qual = rx_rise;
         EDGE_BOTH: rx_qual = rx_rise || rx_fall;
         default: rx_qual = 1'b0;
      endcase
      bus_req = hsel && hready && htrans == HTRANS_NONSEQ;
   end

   // Register bus, engine and pin logic
   always_comb begin
      next_ctl = ctl;
      next_carrier = carrier;
      next_interval = interval;
      next_counter = counter;
      next_flag_if = flag_if;
      next_flag_ov = flag_ov;
      next_manual_tx_level = manual_tx_level;
      next_manual_tx_drive_enable = manual_tx_drive_enable;
      next_wr_pend = bus_req && hwrite;
      next_wr_addr = bus_req ? haddr[7:0] : wr_addr;
      next_hrdata = hrdata;
      next_state = state;
      next_div_cnt = ir_input_clock ? 4'h0 : 4'(div_cnt + 4'h1);
      next_phase_cnt = phase_cnt;
      next_phase_high = phase_high;
      next_lat_carrier = lat_carrier;
      next_lat_data = lat_data;
      next_lat_pol = lat_pol;

      // Software write, data phase
      if (wr_pend) begin
         case (wr_addr)
            ADDR_CONTROL: next_ctl = irt_ctl_t'(hwdata[10:0]);
            ADDR_CARRIER: next_carrier = irt_carrier_t'(hwdata[15:0]);
            ADDR_INTERVAL: next_interval = hwdata[15:0];
            ADDR_COUNTER: next_counter = hwdata[15:0];
            ADDR_STATUS: begin
               next_flag_if = flag_if & hwdata[STS_IF];  // see (R21)
               next_flag_ov = flag_ov & hwdata[STS_OV];
            end
            ADDR_POWER: begin
               next_manual_tx_level = hwdata[PWR_LEVEL];
               next_manual_tx_drive_enable = hwdata[PWR_OE];
            end
            default: ;
         endcase
      end

      // Carrier phase generator
      if (ir_input_clock && state != ST_IDLE) begin
         if (phase_cnt >= phase_top) begin
            next_phase_cnt = 8'h00;
            next_phase_high = !phase_high;
         end else begin
            next_phase_cnt = 8'(phase_cnt + 8'h01);
         end
      end

      case (state)
         ST_IDLE: begin
            if (ctl.enable && ctl.mode) begin  // see (R9)
               next_state = ST_TX;
               next_counter = interval;
               next_lat_carrier = carrier;  // see (R5)
               next_lat_data = ctl.data;
               next_lat_pol = ctl.pol;
               next_phase_cnt = 8'h00;
               next_phase_high = 1'b1;
            end else if (ctl.enable) begin
               next_state = ST_RX_WAIT;  // see (R15)
               next_lat_carrier = carrier;
               next_phase_cnt = 8'h00;
               next_phase_high = 1'b1;
            end
         end
         ST_TX: begin
            if (!ctl.enable || !ctl.mode) begin  // see (R12)
               next_state = ST_IDLE;
            end else if (cnt_tick) begin
               if (counter == CNT_ZERO) begin  // see (R10) see (R11)
                  next_counter = interval;
                  next_lat_carrier = carrier;  // see (R5)
                  next_lat_data = ctl.data;
                  next_lat_pol = ctl.pol;
                  next_phase_cnt = 8'h00;
                  next_phase_high = 1'b1;
                  next_flag_if = 1'b1;
               end else begin
                  next_counter = 16'(counter - 16'h0001);
               end
            end
         end
         ST_RX_WAIT: begin
            if (!ctl.enable || ctl.mode) begin  // see (R19)
               next_state = ST_IDLE;
            end else if (rx_qual) begin
               next_state = ST_RX_RUN;
               next_counter = CNT_ZERO;  // see (R15)
            end
         end
         ST_RX_RUN: begin
            if (!ctl.enable || ctl.mode) begin  // see (R19)
               next_state = ST_IDLE;
            end else begin
               if (cnt_tick) begin
                  next_counter = 16'(counter + 16'h0001);
                  if (counter == CNT_MAX) begin
                     next_flag_ov = 1'b1;  // see (R13)
                  end
               end
               if (rx_qual) begin
                  next_lat_data = rx_sync;  // see (R17)
                  next_ctl.data = rx_sync;
                  next_interval = counter;
                  next_flag_if = 1'b1;  // see (R20)
                  if (ctl.reload) begin
                     next_counter = CNT_ZERO;  // see (R18)
                  end
               end
            end
         end
         default: next_state = ST_IDLE;
      endcase

      // A software counter write wins over the engine's count in the same cycle
      if (wr_pend && wr_addr == ADDR_COUNTER) begin
         next_counter = hwdata[15:0];
      end

      // Read data, address phase
      if (bus_req && !hwrite) begin
         case (haddr[7:0])
            ADDR_CONTROL: next_hrdata = {21'h000000, next_ctl};
            ADDR_CARRIER: next_hrdata = {16'h0000, next_carrier};
            ADDR_INTERVAL: next_hrdata = {16'h0000, next_interval};
            ADDR_COUNTER: next_hrdata = {16'h0000, next_counter};
            ADDR_STATUS: next_hrdata = {30'h00000000, next_flag_ov, next_flag_if};
            ADDR_POWER: begin
               next_hrdata = {30'h00000000, next_manual_tx_drive_enable,
                              next_manual_tx_level};
            end
            default: next_hrdata = 32'h00000000;
         endcase
      end

      // Pin drive
      if (!next_ctl.enable) begin
         next_tx_pin = next_manual_tx_level;  // see (R1)
         next_tx_oe_n = !next_manual_tx_drive_enable;
      end else if (next_state == ST_TX && next_lat_data) begin
         next_tx_pin = next_phase_high ^ next_lat_pol;  // see (R8) see (R6)
         next_tx_oe_n = 1'b0;
      end else begin
         next_tx_pin = (next_state == ST_TX) ? next_lat_pol : next_ctl.pol;  // see (R6)
         next_tx_oe_n = 1'b0;
      end
      next_irq = next_ctl.ie && (next_flag_if || next_flag_ov);  // see (R13)
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         ctl <= '0;
         carrier <= '0;
         interval <= CNT_ZERO;
         counter <= CNT_ZERO;
         flag_if <= 1'b0;
         flag_ov <= 1'b0;
         manual_tx_level <= 1'b0;
         manual_tx_drive_enable <= 1'b0;
         wr_pend <= 1'b0;
         wr_addr <= 8'h00;
         hrdata <= 32'h00000000;
         state <= ST_IDLE;
         div_cnt <= 4'h0;
         phase_cnt <= 8'h00;
         phase_high <= 1'b1;
         lat_carrier <= '0;
         lat_data <= 1'b0;
         lat_pol <= 1'b0;
         rx_meta <= 1'b0;
         rx_sync <= 1'b0;
         rx_prev <= 1'b0;
         ir_tx_pin <= 1'b0;
         ir_tx_pin_oe_n <= 1'b1;
         timer_irq <= 1'b0;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         ctl <= next_ctl;
         carrier <= next_carrier;
         interval <= next_interval;
         counter <= next_counter;
         flag_if <= next_flag_if;
         flag_ov <= next_flag_ov;
         manual_tx_level <= next_manual_tx_level;
         manual_tx_drive_enable <= next_manual_tx_drive_enable;
         wr_pend <= next_wr_pend;
         wr_addr <= next_wr_addr;
         hrdata <= next_hrdata;
         state <= next_state;
         div_cnt <= next_div_cnt;
         phase_cnt <= next_phase_cnt;
         phase_high <= next_phase_high;
         lat_carrier <= next_lat_carrier;
         lat_data <= next_lat_data;
         lat_pol <= next_lat_pol;
         rx_meta <= ir_rx_pin;
         rx_sync <= rx_meta;
         rx_prev <= rx_sync;
         ir_tx_pin <= next_tx_pin;
         ir_tx_pin_oe_n <= next_tx_oe_n;
         timer_irq <= next_irq;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end
endmodule : irt_timer

// >>> testbench.sv
// Self-checking bench for the infrared timer
`timescale 1ns/10ps
module testbench;
   import irt_pkg::*;
   localparam int LIMIT = 6000;
   logic clock, resetn, hsel, hwrite, hready, hreadyout, hresp, rx_level;
   logic ir_rx_pin, ir_tx_pin, ir_tx_pin_oe_n, timer_irq;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [31:0] haddr, hwdata, hrdata, rdv;
   logic [15:0] high_run, low_run;
   int failures, checks_done, cyc, t;
   assign hready = hreadyout;
   irt_timer irt_timer_i (.clock, .resetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
      .hready, .hrdata, .hreadyout, .hresp, .ir_rx_pin, .ir_tx_pin, .ir_tx_pin_oe_n, .timer_irq);
   irt_ir_partner irt_ir_partner_i (.clock, .resetn, .ir_tx_pin, .ir_tx_pin_oe_n, .rx_level,
      .ir_rx_pin, .high_run, .low_run);
   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end
   task automatic finish_test();
      $display("Checks %0d mismatches %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : finish_test
   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (cyc == LIMIT) begin
         failures++;
         finish_test();
      end
   end
   task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= HTRANS_NONSEQ;
      hwrite <= w;
      haddr <= {24'h000000, a};
      do @(posedge clock); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clock); while (hreadyout !== 1'b1);
      rdv = hrdata;
   endtask : acc
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         failures++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic rd(input string n, input logic [7:0] a, input logic [31:0] e);
      acc(1'b0, a, 32'h0);
      chk(n, e, rdv);
   endtask : rd
   task automatic runs(input logic [15:0] h, input logic [15:0] l);
      chk("high run", {16'h0, h}, {16'h0, high_run});
      chk("low run", {16'h0, l}, {16'h0, low_run});
   endtask : runs
   initial begin
      resetn = 1'b0;
      hsel = 1'b0;
      hwrite = 1'b0;
      htrans = 2'h0;
      hsize = 3'h2;
      haddr = 32'h0;
      hwdata = 32'h0;
      rx_level = 1'b0;
      failures = 0;
      checks_done = 0;
      cyc = 0;
      repeat (4) @(posedge clock);
      resetn <= 1'b1;
      @(posedge clock);
      rd("control", ADDR_CONTROL, 32'h0);
      rd("unmapped", 8'h20, 32'h0);
      acc(1'b1, ADDR_CARRIER, 32'hFFFF1234);
      rd("carrier", ADDR_CARRIER, 32'h1234);
      acc(1'b1, ADDR_POWER, 32'h3);
      repeat (2) @(posedge clock);
      chk("manual level", 32'h1, {31'h0, ir_tx_pin});
      acc(1'b1, ADDR_POWER, 32'h1);
      repeat (2) @(posedge clock);
      chk("manual drive", 32'h1, {31'h0, ir_tx_pin_oe_n});
      $display("Test registers done");
      acc(1'b1, ADDR_CARRIER, 32'h0204);
      acc(1'b1, ADDR_INTERVAL, 32'h3);
      for (int pol = 0; pol < 2; pol++) begin
         acc(1'b1, ADDR_CONTROL, 32'h232 | (pol << CTL_POL));
         acc(1'b1, ADDR_CONTROL, 32'h233 | (pol << CTL_POL));
         repeat (300) @(posedge clock);
         runs(pol ? 16'hA : 16'h6, pol ? 16'h6 : 16'hA);
      end
      chk("tx irq", 32'h1, {31'h0, timer_irq});
      acc(1'b1, ADDR_CARRIER, 32'h0101);
      repeat (200) @(posedge clock);
      runs(16'h4, 16'h4);
      rd("tx flag", ADDR_STATUS, 32'h1);
      acc(1'b1, ADDR_CONTROL, 32'h0);
      acc(1'b1, ADDR_STATUS, 32'h0);
      rd("cleared", ADDR_STATUS, 32'h0);
      acc(1'b1, ADDR_CARRIER, 32'h0005);
      acc(1'b1, ADDR_INTERVAL, 32'h2);
      acc(1'b1, ADDR_CONTROL, 32'h17);
      repeat (100) @(posedge clock);
      runs(16'h1, 16'h2);
      acc(1'b1, ADDR_CONTROL, 32'h0F);
      repeat (300) @(posedge clock);
      chk("data 0 idle", 32'h1, {31'h0, ir_tx_pin});
      acc(1'b1, ADDR_CONTROL, 32'h0);
      $display("Test transmit done");
      acc(1'b1, ADDR_CONTROL, 32'h1E5);
      repeat (5) @(posedge clock);
      rx_level <= 1'b1;
      t = cyc;
      for (int i = 0; i < 2; i++) begin
         while (cyc < t + 40) @(posedge clock);
         rx_level <= i[0];
         t = cyc;
         repeat (10) @(posedge clock);
         rd("rx data", ADDR_CONTROL, 32'h1E5 | (i << CTL_DATA));
         acc(1'b0, ADDR_INTERVAL, 32'h0);
         chk("interval", 32'h1, {31'h0, rdv[15:0] inside {[16'h0027:16'h0029]}});
      end
      rd("rx flag", ADDR_STATUS, 32'h1);
      acc(1'b1, ADDR_CONTROL, 32'hA5);
      rx_level <= 1'b0;
      repeat (10) @(posedge clock);
      acc(1'b1, ADDR_STATUS, 32'h0);
      rx_level <= 1'b1;
      repeat (10) @(posedge clock);
      rd("rise", ADDR_STATUS, 32'h0);
      rx_level <= 1'b0;
      repeat (10) @(posedge clock);
      rd("fall", ADDR_STATUS, 32'h1);
      acc(1'b1, ADDR_COUNTER, 32'hFFF0);
      repeat (40) @(posedge clock);
      rd("overflow", ADDR_STATUS, 32'h3);
      chk("rx irq", 32'h1, {31'h0, timer_irq});
      acc(1'b1, ADDR_CONTROL, 32'h85);
      repeat (2) @(posedge clock);
      chk("masked", 32'h0, {31'h0, timer_irq});
      acc(1'b1, ADDR_CONTROL, 32'h0);
      $display("Test receive done");
      finish_test();
   end
endmodule : testbench
bind irt_timer irt_asserts irt_asserts_i (.clock, .resetn, .hsel, .haddr, .htrans, .hwrite,
   .hwdata, .hready, .hreadyout, .hresp, .ir_tx_pin, .ir_tx_pin_oe_n, .timer_irq);
